// ===== core/dss_core.sv
// Purpose: safety sensor evaluation for a door drive, Wishbone register slave
// Assumes: motion inputs and fieldbus flags come from logic on clk_i
// Notes:   responses are registered levels for the motion control
`timescale 1ns/1ps
`include "dss_defs.svh"

module dss_core
#(
  parameter int TEST_HALF = (`DSS_TEST_HALF_NS + `DSS_CLK_NS - 1) / `DSS_CLK_NS
)
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                shared_input_i,
  input  wire logic                beam_sensor_bit_i,
  input  wire logic                fieldbus_operating_state_i,
  input  wire dss_pkg::dss_mode_t  mode_i,
  input  wire dss_pkg::dss_motion_t motion_i,
  output dss_pkg::dss_resp_t       resp_o,
  output logic                     sensor_test_output_o
);

  dss_pkg::dss_regs_t s;
  dss_pkg::dss_regs_t next_s;
  logic               pin_level;
  logic               beam_clear;
  logic               curtain_clear;
  logic               edge_intact;
  logic               in_range;
  logic               near_open;
  logic               beam_act;
  logic               curtain_act;
  logic               edge_act;
  logic               lc_act;
  logic               ramp_level;
  logic               wr_en;
  logic               test_type;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction

  function automatic logic [15:0] abs_diff(input logic [15:0] a,
                                           input logic [15:0] b);
    return (a > b) ? 16'(a - b) : 16'(b - a);
  endfunction

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  dss_sync u_sync
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (shared_input_i),
    .level_o (pin_level)
  );

  // ----------------------------------------
  // sensor interpretation
  // ----------------------------------------
  always_comb
  begin
    beam_clear    = 1'b1;
    curtain_clear = 1'b1;
    edge_intact   = 1'b1;
    if (s.fb_en)
      beam_clear = fieldbus_operating_state_i ? beam_sensor_bit_i : 1'b1;
    else if (s.sensor_type == dss_pkg::DSS_SENS_BEAM)
      beam_clear = pin_level;
    if (s.sensor_type == dss_pkg::DSS_SENS_CURTAIN)
      curtain_clear = pin_level;
    if (s.sensor_type == dss_pkg::DSS_SENS_EDGE)
      edge_intact = pin_level;
    in_range    = motion_i.door_pos <= s.range;
    near_open   = abs_diff(motion_i.door_pos, motion_i.open_pos) <= `DSS_EDGE_OPEN_MM;
    beam_act    = !beam_clear && in_range
                  && (motion_i.door_pos >= `DSS_BEAM_IGNORE_MM);
    curtain_act = !curtain_clear && in_range;
    edge_act    = !edge_intact && in_range && !near_open;
    lc_act      = beam_act || curtain_act;
    test_type   = (s.sensor_type == dss_pkg::DSS_SENS_CURTAIN)
                  || (s.sensor_type == dss_pkg::DSS_SENS_EDGE);
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_s     = s;
    ramp_level = 1'b0;
    wr_en      = s.wb_ack && wb_cyc_i && wb_stb_i && wb_we_i;

    unique case (s.st)
      dss_pkg::DSS_ST_IDLE:
        unique case (mode_i)
          dss_pkg::DSS_MODE_LEARN:
            if (lc_act || edge_act)
              next_s.st = dss_pkg::DSS_ST_ABORTED;
          dss_pkg::DSS_MODE_INITIAL:
          begin
            ramp_level = lc_act && motion_i.close_order;
            if (edge_act)
              next_s.st = dss_pkg::DSS_ST_HALTED;
          end
          dss_pkg::DSS_MODE_NORMAL:
            if (lc_act && motion_i.close_order)
              next_s.st = dss_pkg::DSS_ST_REVERSING;
            else if (edge_act)
              next_s.st = dss_pkg::DSS_ST_EDGE_REVERSE;
          dss_pkg::DSS_MODE_POSITIONING:
          begin
            ramp_level = lc_act;
            if (edge_act)
              next_s.st = dss_pkg::DSS_ST_HALTED;
          end
          dss_pkg::DSS_MODE_SPECIAL:
            ramp_level = lc_act && motion_i.close_order;
          default:
            ramp_level = 1'b0;
        endcase
      dss_pkg::DSS_ST_REVERSING:
        if (motion_i.obstruct)
          next_s.st = dss_pkg::DSS_ST_ORDERED;
        else if (motion_i.reverse_done)
          next_s.st = dss_pkg::DSS_ST_IDLE;
      dss_pkg::DSS_ST_ORDERED:
        if (!motion_i.close_order)
          next_s.st = dss_pkg::DSS_ST_IDLE;
      dss_pkg::DSS_ST_EDGE_REVERSE:
        if (motion_i.obstruct)
          next_s.st = dss_pkg::DSS_ST_HALTED;
        else if (motion_i.reverse_done)
          next_s.st = dss_pkg::DSS_ST_IDLE;
      dss_pkg::DSS_ST_HALTED:
        if (!motion_i.close_order && !edge_act)
          next_s.st = dss_pkg::DSS_ST_IDLE;
      dss_pkg::DSS_ST_ABORTED:
        if (mode_i != dss_pkg::DSS_MODE_LEARN)
          next_s.st = dss_pkg::DSS_ST_IDLE;
      default:
        next_s.st = dss_pkg::DSS_ST_IDLE;
    endcase

    // response outputs, registered
    next_s.resp.abort_learn      = next_s.st == dss_pkg::DSS_ST_ABORTED;
    next_s.resp.deenergize       = (next_s.st == dss_pkg::DSS_ST_ABORTED)
                                   || (next_s.st == dss_pkg::DSS_ST_HALTED);
    next_s.resp.ramp_stop        = ramp_level || (next_s.st == dss_pkg::DSS_ST_HALTED);
    next_s.resp.reverse          = (next_s.st == dss_pkg::DSS_ST_REVERSING)
                                   || (next_s.st == dss_pkg::DSS_ST_EDGE_REVERSE);
    next_s.resp.reverse_dist     = (next_s.st == dss_pkg::DSS_ST_EDGE_REVERSE)
                                   ? `DSS_EDGE_REV_MM : 16'h0000;
    next_s.resp.post_order_valid = next_s.st == dss_pkg::DSS_ST_ORDERED;
    next_s.resp.post_order       = s.order;

    // sensor test output only for curtain and edge
    if (test_type)
    begin
      if (s.test_cnt == 16'(TEST_HALF - 1))
      begin
        next_s.test_cnt = 16'h0000;
        next_s.test_out = !s.test_out;
      end
      else
        next_s.test_cnt = 16'(s.test_cnt + 16'h0001);
    end
    else
    begin
      next_s.test_cnt = 16'h0000;
      next_s.test_out = 1'b0;
    end

    // wishbone slave
    next_s.wb_ack = wb_cyc_i && wb_stb_i && !s.wb_ack;
    next_s.wb_dat = 32'h00000000;
    unique case (wb_adr_i)
      `DSS_ADR_CTRL:
      begin
        next_s.wb_dat[`DSS_CTRL_TYPE_LSB +: 3] = s.sensor_type;
        next_s.wb_dat[`DSS_CTRL_FBEN_BIT]      = s.fb_en;
      end
      `DSS_ADR_RANGE:
        next_s.wb_dat[15:0] = s.range;
      `DSS_ADR_ORDER:
        next_s.wb_dat[1:0] = s.order;
      `DSS_ADR_STATUS:
      begin
        next_s.wb_dat[0] = pin_level;
        next_s.wb_dat[1] = beam_clear;
        next_s.wb_dat[2] = lc_act;
        next_s.wb_dat[3] = edge_act;
        next_s.wb_dat[`DSS_STAT_STATE_LSB +: 3] = s.st;
      end
      default:
        next_s.wb_dat = 32'h00000000;
    endcase
    if (wr_en)
    begin
      unique case (wb_adr_i)
        `DSS_ADR_CTRL:
        begin
          next_s.sensor_type = 3'(wb_merge({27'h0, s.fb_en, 1'b0, s.sensor_type},
                                           wb_dat_i, wb_sel_i));
          next_s.fb_en       = wb_sel_i[0] ? wb_dat_i[`DSS_CTRL_FBEN_BIT] : s.fb_en;
        end
        `DSS_ADR_RANGE:
          next_s.range = 16'(wb_merge({16'h0, s.range}, wb_dat_i, wb_sel_i));
        `DSS_ADR_ORDER:
          next_s.order = 2'(wb_merge({30'h0, s.order}, wb_dat_i, wb_sel_i));
        default:
          next_s.order = s.order;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s             <= '0;
      s.st          <= dss_pkg::DSS_ST_IDLE;
      s.sensor_type <= `DSS_RST_TYPE;
      s.fb_en       <= `DSS_RST_FBEN;
      s.range       <= `DSS_RST_RANGE;
      s.order       <= `DSS_RST_ORDER;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign wb_dat_o             = s.wb_dat;
  assign wb_ack_o             = s.wb_ack;
  assign resp_o               = s.resp;
  assign sensor_test_output_o = s.test_out;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_learn_abort;
    (s.st == dss_pkg::DSS_ST_IDLE) && (mode_i == dss_pkg::DSS_MODE_LEARN)
      && (lc_act || edge_act) |=> resp_o.abort_learn && resp_o.deenergize;
  endproperty
  a_learn_abort: assert property (p_learn_abort)
    else $error("learn run not aborted");

  property p_initial_ramp;
    (s.st == dss_pkg::DSS_ST_IDLE) && (mode_i == dss_pkg::DSS_MODE_INITIAL)
      && lc_act && motion_i.close_order |=> resp_o.ramp_stop && !resp_o.reverse;
  endproperty
  a_initial_ramp: assert property (p_initial_ramp)
    else $error("no ramp stop in initial mode");

  property p_normal_reverse;
    (s.st == dss_pkg::DSS_ST_IDLE) && (mode_i == dss_pkg::DSS_MODE_NORMAL)
      && lc_act && motion_i.close_order |=> resp_o.reverse ##0 (resp_o.reverse_dist == 16'h0000);
  endproperty
  a_normal_reverse: assert property (p_normal_reverse)
    else $error("no reversal in normal mode");

  property p_pos_ramp;
    (s.st == dss_pkg::DSS_ST_IDLE) && (mode_i == dss_pkg::DSS_MODE_POSITIONING)
      && lc_act |=> resp_o.ramp_stop && !resp_o.reverse;
  endproperty
  a_pos_ramp: assert property (p_pos_ramp)
    else $error("no ramp stop in positioning mode");

  property p_edge_halt;
    (s.st == dss_pkg::DSS_ST_EDGE_REVERSE) && motion_i.obstruct
      |=> resp_o.deenergize && !resp_o.reverse;
  endproperty
  a_edge_halt: assert property (p_edge_halt)
    else $error("edge reversal obstruction not halted");

  property p_beam_no_test;
    (s.sensor_type == dss_pkg::DSS_SENS_BEAM) [*2] |-> !sensor_test_output_o;
  endproperty
  a_beam_no_test: assert property (p_beam_no_test)
    else $error("test output driven for light barrier");

  property p_curtain_test;
    (s.sensor_type == dss_pkg::DSS_SENS_CURTAIN) && (s.test_cnt == 16'(TEST_HALF - 1))
      |=> sensor_test_output_o != $past(sensor_test_output_o);
  endproperty
  a_curtain_test: assert property (p_curtain_test)
    else $error("curtain test output did not toggle");

  property p_edge_test;
    (s.sensor_type == dss_pkg::DSS_SENS_EDGE) && (s.test_cnt == 16'(TEST_HALF - 1))
      |=> sensor_test_output_o != $past(sensor_test_output_o);
  endproperty
  a_edge_test: assert property (p_edge_test)
    else $error("edge test output did not toggle");

  property p_fb_rest;
    s.fb_en && !fieldbus_operating_state_i && !test_type && (s.st == dss_pkg::DSS_ST_IDLE)
      |=> !resp_o.reverse && !resp_o.ramp_stop && !resp_o.abort_learn;
  endproperty
  a_fb_rest: assert property (p_fb_rest)
    else $error("fieldbus bit acted outside operating state");

  property p_open_band;
    (s.sensor_type == dss_pkg::DSS_SENS_EDGE) && near_open && !lc_act
      && (s.st == dss_pkg::DSS_ST_IDLE) |=> !resp_o.reverse && !resp_o.deenergize;
  endproperty
  a_open_band: assert property (p_open_band)
    else $error("edge acted near open position");

endmodule

// ===== core/dss_defs.svh
// Purpose: offsets, fields, reset values, distances and nanosecond timings of the sensor response block
// Assumes: 32-bit classic Wishbone, byte addresses, 25 MHz clock
// Notes:   distances are in millimetres of door travel from the closed position
`ifndef DSS_DEFS_SVH
`define DSS_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DSS_ADR_CTRL        8'h00
`define DSS_ADR_RANGE       8'h04
`define DSS_ADR_ORDER       8'h08
`define DSS_ADR_STATUS      8'h0C

// ----------------------------------------
// field positions
// ----------------------------------------
`define DSS_CTRL_TYPE_LSB   0
`define DSS_CTRL_FBEN_BIT   4
`define DSS_STAT_STATE_LSB  4

// ----------------------------------------
// reset values
// ----------------------------------------
`define DSS_RST_TYPE        3'h0
`define DSS_RST_FBEN        1'h0
`define DSS_RST_RANGE       16'hFFFF
`define DSS_RST_ORDER       2'h0

// ----------------------------------------
// distances and timing
// ----------------------------------------
`define DSS_BEAM_IGNORE_MM  16'h000A
`define DSS_EDGE_OPEN_MM    16'h0014
`define DSS_EDGE_REV_MM     16'h00C8
`define DSS_CLK_NS          40
`define DSS_TEST_HALF_NS    10000

`endif

// ===== core/dss_pkg.sv
// Purpose: types of the sensor response block
// Assumes: used as dss_pkg::name, never imported
// Notes:   sensor type codes above the last one are illegal
package dss_pkg;

  typedef enum logic [2:0] {
    DSS_SENS_INACTIVE,
    DSS_SENS_BEAM,
    DSS_SENS_DOOR_CTRL,
    DSS_SENS_CURTAIN,
    DSS_SENS_EDGE
  } dss_sensor_t;

  typedef enum logic [2:0] {
    DSS_MODE_LEARN,
    DSS_MODE_INITIAL,
    DSS_MODE_NORMAL,
    DSS_MODE_POSITIONING,
    DSS_MODE_SPECIAL
  } dss_mode_t;

  typedef enum logic [2:0] {
    DSS_ST_IDLE,
    DSS_ST_REVERSING,
    DSS_ST_ORDERED,
    DSS_ST_EDGE_REVERSE,
    DSS_ST_HALTED,
    DSS_ST_ABORTED
  } dss_state_t;

  typedef struct packed {
    logic [15:0] door_pos;
    logic [15:0] open_pos;
    logic        close_order;
    logic        reverse_done;
    logic        obstruct;
  } dss_motion_t;

  typedef struct packed {
    logic        abort_learn;
    logic        deenergize;
    logic        ramp_stop;
    logic        reverse;
    logic [15:0] reverse_dist;
    logic        post_order_valid;
    logic [1:0]  post_order;
  } dss_resp_t;

  typedef struct packed {
    dss_state_t  st;
    logic [2:0]  sensor_type;
    logic        fb_en;
    logic [15:0] range;
    logic [1:0]  order;
    logic [15:0] test_cnt;
    logic        test_out;
    logic        wb_ack;
    logic [31:0] wb_dat;
    dss_resp_t   resp;
  } dss_regs_t;

  typedef struct packed {
    logic meta;
    logic stable;
  } dss_sync_t;

endpackage

// ===== core/dss_sync.sv
// Purpose: two-flop synchroniser for the shared sensor pin
// Assumes: pin is asynchronous to clk_i
// Notes:   meta is read only by the second flop
`timescale 1ns/1ps

module dss_sync
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o
);

  dss_pkg::dss_sync_t s;
  dss_pkg::dss_sync_t next_s;

  // ----------------------------------------
  // state update
  // ----------------------------------------
  always_comb
  begin
    next_s        = s;
    next_s.meta   = pin_i;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '{meta: 1'b1, stable: 1'b1};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign level_o = s.stable;

endmodule

// ===== tb/dss_sensor_model.sv
// Purpose: far-side model of the sensor pin and the supervising controller's beam bit
// Assumes: sensor drives the pin high while clear or intact
// Notes:   both levels follow the bench's blocking commands at once
`timescale 1ns/1ps

module dss_sensor_model
(
  input  wire logic pin_block_i,
  input  wire logic plc_block_i,
  output logic      pin_o,
  output logic      beam_bit_o
);
  // ----------------------------------------
  // sensor and controller levels
  // ----------------------------------------
  assign pin_o      = ~pin_block_i;
  assign beam_bit_o = ~plc_block_i;
endmodule

// ===== tb/testbench.sv
// Purpose: self-checking bench of the sensor response block
// Assumes: Wishbone master waits for ack, no fixed latency
// Notes:   each scenario resets and reconfigures the block
`timescale 1ns/1ps

module testbench;
  logic                  clk, rst, cyc, stb, we, fb_op, pin_blk, plc_blk, pin, beam, ack, tout;
  logic [7:0]            adr;
  logic [31:0]           wdat, rdat, q;
  dss_pkg::dss_mode_t    mode;
  dss_pkg::dss_motion_t  motion;
  dss_pkg::dss_resp_t    resp;
  int                    bad_count, total_checks;
  localparam dss_pkg::dss_mode_t LRN = dss_pkg::DSS_MODE_LEARN;
  localparam dss_pkg::dss_mode_t INI = dss_pkg::DSS_MODE_INITIAL;
  localparam dss_pkg::dss_mode_t NRM = dss_pkg::DSS_MODE_NORMAL;
  localparam dss_pkg::dss_mode_t POS = dss_pkg::DSS_MODE_POSITIONING;
  localparam dss_pkg::dss_mode_t SPC = dss_pkg::DSS_MODE_SPECIAL;

  dss_core #(.TEST_HALF(4)) DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .shared_input_i(pin), .beam_sensor_bit_i(beam),
    .fieldbus_operating_state_i(fb_op), .mode_i(mode), .motion_i(motion), .resp_o(resp),
    .sensor_test_output_o(tout));
  dss_sensor_model partner (.pin_block_i(pin_blk), .plc_block_i(plc_blk), .pin_o(pin),
    .beam_bit_o(beam));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    r = rdat;
    if (n >= 50) bad_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic setup(input logic [7:0] c);
    @(posedge clk);
    rst <= 1'b1;
    pin_blk <= 1'b0;
    plc_blk <= 1'b0;
    fb_op <= 1'b0;
    motion <= '0;
    mode <= INI;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    xfer(1'b1, 8'h00, {24'h0, c}, q);
    xfer(1'b1, 8'h04, 32'h258, q);
    xfer(1'b1, 8'h08, 32'h2, q);
  endtask

  task automatic scen(input logic [7:0] c, input dss_pkg::dss_mode_t m, input logic [15:0] p,
                      input logic cl, pb, fb, op, input logic [3:0] e);
    setup(c);
    @(posedge clk);
    mode <= m;
    motion <= '{door_pos: p, open_pos: 16'h01F4, close_order: cl, reverse_done: 1'b0,
                obstruct: 1'b0};
    pin_blk <= pb;
    plc_blk <= fb;
    fb_op <= op;
    @(posedge clk);
    @(negedge clk);
    if (!op) check(32'(resp.reverse | resp.ramp_stop | resp.abort_learn), 32'h0);
    repeat (8) @(posedge clk);
    @(negedge clk);
    check(32'({resp.abort_learn, resp.deenergize, resp.ramp_stop, resp.reverse}), 32'(e));
    $display("scenario done at %0t", $time);
  endtask

  task automatic hit;
    @(posedge clk);
    motion.obstruct <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic toggles(input logic [7:0] c, input int e);
    int n;
    logic prev;
    n = 0;
    setup(c);
    repeat (4) @(negedge clk);
    prev = tout;
    repeat (32)
    begin
      @(negedge clk);
      if (tout !== prev) n++;
      prev = tout;
    end
    check(32'(n), 32'(e));
    $display("test output check done at %0t", $time);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out;
  end

  initial
  begin
    rst = 1'b1;
    {cyc, stb, we, fb_op, pin_blk, plc_blk} = '0;
    adr = '0;
    wdat = '0;
    mode = INI;
    motion = '0;
    bad_count = 0;
    total_checks = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    xfer(1'b0, 8'h00, 32'h0, q);
    check(q, 32'h0);
    xfer(1'b0, 8'h04, 32'h0, q);
    check(q, 32'h0000FFFF);
    xfer(1'b0, 8'h08, 32'h0, q);
    check(q, 32'h0);
    xfer(1'b1, 8'h10, 32'h5A, q);
    xfer(1'b0, 8'h10, 32'h0, q);
    check(q, 32'h0);
    xfer(1'b1, 8'h00, 32'h3, q);
    xfer(1'b0, 8'h00, 32'h0, q);
    check(q, 32'h3);
    $display("register checks done at %0t", $time);
    scen(8'h03, LRN, 16'h0064, 1, 1, 0, 0, 4'b1100);
    scen(8'h01, LRN, 16'h0064, 1, 1, 0, 0, 4'b1100);
    scen(8'h03, INI, 16'h0064, 1, 1, 0, 0, 4'b0010);
    scen(8'h01, SPC, 16'h0064, 1, 1, 0, 0, 4'b0010);
    scen(8'h01, POS, 16'h0064, 0, 1, 0, 0, 4'b0010);
    scen(8'h01, NRM, 16'h0064, 0, 1, 0, 0, 4'b0000);
    scen(8'h03, NRM, 16'h0064, 1, 0, 0, 0, 4'b0000);
    scen(8'h03, NRM, 16'h0259, 1, 1, 0, 0, 4'b0000);
    scen(8'h01, NRM, 16'h0009, 1, 1, 0, 0, 4'b0000);
    scen(8'h01, NRM, 16'h000A, 1, 1, 0, 0, 4'b0001);
    scen(8'h04, INI, 16'h0064, 1, 1, 0, 0, 4'b0110);
    scen(8'h04, SPC, 16'h0064, 1, 1, 0, 0, 4'b0000);
    scen(8'h04, LRN, 16'h0064, 1, 1, 0, 0, 4'b1100);
    scen(8'h04, NRM, 16'h01E0, 1, 1, 0, 0, 4'b0000);
    scen(8'h04, NRM, 16'h01DF, 1, 1, 0, 0, 4'b0001);
    scen(8'h04, NRM, 16'h0259, 1, 1, 0, 0, 4'b0000);
    scen(8'h02, NRM, 16'h0064, 1, 1, 0, 0, 4'b0000);
    scen(8'h00, NRM, 16'h0064, 1, 1, 0, 0, 4'b0000);
    scen(8'h11, NRM, 16'h0064, 1, 0, 1, 0, 4'b0000);
    scen(8'h11, NRM, 16'h0064, 1, 0, 1, 1, 4'b0001);
    scen(8'h11, NRM, 16'h0064, 1, 1, 0, 1, 4'b0000);
    scen(8'h03, NRM, 16'h0258, 1, 1, 0, 0, 4'b0001);
    hit;
    check(32'({resp.post_order_valid, resp.post_order, resp.reverse}), 32'hC);
    scen(8'h04, NRM, 16'h0064, 1, 1, 0, 0, 4'b0001);
    check(32'(resp.reverse_dist), 32'h00C8);
    hit;
    check(32'({resp.deenergize, resp.ramp_stop}), 32'h3);
    xfer(1'b0, 8'h0C, 32'h0, q);
    check(q, 32'h0000004A);
    toggles(8'h03, 8);
    toggles(8'h04, 8);
    toggles(8'h01, 0);
    close_out;
  end
endmodule
